// File: logic/spsc_pkg.sv
package spsc_pkg;

   // ------------------------------------------------------------
   // Register bus widths and addresses
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 8;
   localparam logic [11:0] ADDR_PLL_ENABLE = 12'h280;
   localparam logic [11:0] ADDR_PLL_STATUS = 12'h281;
   localparam logic [11:0] ADDR_REF_DIV    = 12'h289;
   localparam logic [11:0] ADDR_TERM_CAL   = 12'h2a7;
   localparam logic [11:0] ADDR_LINK_CTRL0 = 12'h300;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_PUMP_HIGH   = 5;
   localparam int BIT_PUMP_LOW    = 4;
   localparam int BIT_CAL_GOOD    = 3;
   localparam int BIT_OSC_CAL_RUN = 2;
   localparam int BIT_BIAS_OK     = 1;
   localparam int BIT_LOCKED      = 0;
   localparam int BIT_RECAL       = 2;
   localparam int BIT_ENABLE      = 0;
   localparam int BIT_TERM_TRIG   = 0;
   localparam int BIT_CHECKSUM    = 6;
   localparam int BIT_LINK_EN     = 0;
   localparam int DIV_LSB         = 0;
   localparam int DIV_MSB         = 1;

   // ------------------------------------------------------------
   // Reset values and masks
   // ------------------------------------------------------------
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [7:0] RST_REF_DIV    = 8'h04;
   localparam logic [7:0] MASK_ENABLE    = 8'hfd;
   localparam logic [7:0] MASK_TERM      = 8'h01;
   localparam logic [7:0] MASK_LINK0     = 8'h41;

   // ------------------------------------------------------------
   // Divider codes and counts
   // ------------------------------------------------------------
   localparam logic [1:0] DIV_BY4 = 2'h0;
   localparam logic [1:0] DIV_BY2 = 2'h1;
   localparam logic [1:0] DIV_BY1 = 2'h2;
   localparam logic [1:0] CNT_BY4 = 2'h3;
   localparam logic [1:0] CNT_BY2 = 2'h1;
   localparam logic [1:0] CNT_BY1 = 2'h0;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic pump_high;
      logic pump_low;
      logic bias_ok;
      logic locked;
      logic cal_done;
      logic cal_ok;
   } spsc_pll_sense_t;

   typedef struct packed {
      logic       enable;
      logic       cal_start;
      logic [1:0] div_sel;
   } spsc_pll_ctrl_t;

   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_BIAS_WAIT,
      CAL_RUN
   } spsc_cal_state_t;

endpackage : spsc_pkg

// File: logic/spsc_ref_divider.sv
`timescale 1ns/10ps
module spsc_ref_divider (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   input  wire logic       ref_tick_i,
   input  wire logic [1:0] div_sel_i,
   output logic            pfd_tick_o
);

   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic       tick_q;
   logic       tick_d;

   // ------------------------------------------------------------
   // Terminal count per code
   // ------------------------------------------------------------
   function automatic logic [1:0] last_count(input logic [1:0] sel);
      case (sel)
         spsc_pkg::DIV_BY4: last_count = spsc_pkg::CNT_BY4;
         spsc_pkg::DIV_BY2: last_count = spsc_pkg::CNT_BY2;
         spsc_pkg::DIV_BY1: last_count = spsc_pkg::CNT_BY1;
         default:           last_count = spsc_pkg::CNT_BY1;
      endcase
   endfunction : last_count

   always_comb begin
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (ref_tick_i) begin
         if (cnt_q >= last_count(div_sel_i)) begin // see R7
            cnt_d  = 2'h0;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q  <= 2'h0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign pfd_tick_o = tick_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_DIV_ONE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R7
      (div_sel_i == spsc_pkg::DIV_BY1 && ref_tick_i) |=> pfd_tick_o)
      else $error("divide by one lost a reference tick");

   AST_DIV_FOUR: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R7
      (div_sel_i == spsc_pkg::DIV_BY4 && cnt_q == 2'h0 && ref_tick_i)
      |=> !pfd_tick_o)
      else $error("divide by four ticked too early");

endmodule : spsc_ref_divider

// File: logic/spsc_pll_regs.sv
// Behaviour
// R1 - Status bit 5 shows charge pump out of range high.
// R2 - Status bit 4 shows charge pump out of range low.
// R3 - Status bit 3 set once PLL calibration finished successfully.
// R4 - Status bit 2 reads 1 while oscillator calibration runs.
// R5 - Status bit 1 reads 1 once bias currents are ready.
// R6 - Status bit 0 follows PLL lock; read-only.
// R7 - Divider code 00 divides reference by 4, 01 by 2, 10 by 1.
// R8 - Software keeps divided reference between 35 and 80 MHz.
// R9 - Software picks division from lane rate.
// R10 - Software writes ones into divider register bits 7 to 2.
// R11 - Rising edge on termination bit 0 starts termination calibration.
// R12 - Rising edge on recalibrate bit 2 restarts PLL calibration.
// R13 - Setting enable bit 0 enables PLL and starts calibration.
// R14 - Status reads zero after reset, tracks PLL; writes ignored.
`timescale 1ns/10ps
module spsc_pll_regs (
   input  wire logic                     sys_clk_i,
   input  wire logic                     rst_i,
   input  wire logic [11:0]              cfg_addr_i,
   input  wire logic                     cfg_wr_i,
   input  wire logic                     cfg_rd_i,
   input  wire logic [7:0]               cfg_wdata_i,
   output logic      [7:0]               cfg_rdata_o,
   output logic                          cfg_rvalid_o,
   input  wire spsc_pkg::spsc_pll_sense_t pll_sense_i,
   output spsc_pkg::spsc_pll_ctrl_t      pll_ctrl_o,
   input  wire logic                     ref_tick_i,
   output logic                          pfd_tick_o,
   output logic                          term_cal_start_o,
   output logic                          link_en_o,
   output logic                          checksum_mode_o
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [7:0]                enable_q;
   logic [7:0]                enable_d;
   logic [7:0]                ref_div_q;
   logic [7:0]                ref_div_d;
   logic [7:0]                term_q;
   logic [7:0]                term_d;
   logic [7:0]                link0_q;
   logic [7:0]                link0_d;
   logic [7:0]                status_q;
   logic [7:0]                status_d;
   logic [7:0]                rdata_q;
   logic [7:0]                rdata_d;
   logic                      rvalid_q;
   logic                      rvalid_d;
   logic                      term_start_q;
   logic                      term_start_d;
   spsc_pkg::spsc_cal_state_t state_q;
   spsc_pkg::spsc_cal_state_t state_d;
   logic                      good_q;
   logic                      good_d;
   spsc_pkg::spsc_pll_ctrl_t  ctrl_q;
   spsc_pkg::spsc_pll_ctrl_t  ctrl_d;
   logic                      cal_trigger;
   logic                      wr_enable;
   logic                      wr_term;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic rising(input logic old_v, input logic new_v);
      rising = !old_v && new_v;
   endfunction : rising

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction : hit

   assign wr_enable = cfg_wr_i && hit(cfg_addr_i, spsc_pkg::ADDR_PLL_ENABLE);
   assign wr_term   = cfg_wr_i && hit(cfg_addr_i, spsc_pkg::ADDR_TERM_CAL);

   // ------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------
   always_comb begin
      enable_d     = enable_q;
      ref_div_d    = ref_div_q;
      term_d       = term_q;
      link0_d      = link0_q;
      term_start_d = 1'b0;
      cal_trigger  = 1'b0;
      if (wr_enable) begin
         enable_d = cfg_wdata_i & spsc_pkg::MASK_ENABLE;
         if (rising(enable_q[spsc_pkg::BIT_ENABLE], cfg_wdata_i[spsc_pkg::BIT_ENABLE])) begin
            cal_trigger = 1'b1; // see R13
         end
         if (rising(enable_q[spsc_pkg::BIT_RECAL], cfg_wdata_i[spsc_pkg::BIT_RECAL])) begin
            cal_trigger = 1'b1; // see R12
         end
      end
      if (cfg_wr_i && hit(cfg_addr_i, spsc_pkg::ADDR_REF_DIV)) begin
         ref_div_d = cfg_wdata_i;
      end
      if (wr_term) begin
         term_d = cfg_wdata_i & spsc_pkg::MASK_TERM;
         term_start_d = rising(term_q[spsc_pkg::BIT_TERM_TRIG],
                               cfg_wdata_i[spsc_pkg::BIT_TERM_TRIG]); // see R11
      end
      if (cfg_wr_i && hit(cfg_addr_i, spsc_pkg::ADDR_LINK_CTRL0)) begin
         link0_d = cfg_wdata_i & spsc_pkg::MASK_LINK0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         enable_q     <= spsc_pkg::RST_ZERO;
         ref_div_q    <= spsc_pkg::RST_REF_DIV;
         term_q       <= spsc_pkg::RST_ZERO;
         link0_q      <= spsc_pkg::RST_ZERO;
         term_start_q <= 1'b0;
      end else begin
         enable_q     <= enable_d;
         ref_div_q    <= ref_div_d;
         term_q       <= term_d;
         link0_q      <= link0_d;
         term_start_q <= term_start_d;
      end
   end

   // ------------------------------------------------------------
   // Calibration sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d          = state_q;
      good_d           = good_q;
      ctrl_d           = ctrl_q;
      ctrl_d.cal_start = 1'b0;
      ctrl_d.enable    = enable_d[spsc_pkg::BIT_ENABLE]; // see R13
      ctrl_d.div_sel   = ref_div_d[spsc_pkg::DIV_MSB:spsc_pkg::DIV_LSB]; // see R7
      case (state_q)
         spsc_pkg::CAL_IDLE: begin
            if (cal_trigger) begin
               state_d = spsc_pkg::CAL_BIAS_WAIT;
               good_d  = 1'b0;
            end
         end
         spsc_pkg::CAL_BIAS_WAIT: begin
            if (cal_trigger) begin
               state_d = spsc_pkg::CAL_BIAS_WAIT; // see R12
               good_d  = 1'b0;
            end else if (pll_sense_i.bias_ok) begin
               state_d          = spsc_pkg::CAL_RUN;
               ctrl_d.cal_start = 1'b1;
            end
         end
         spsc_pkg::CAL_RUN: begin
            if (cal_trigger) begin
               state_d = spsc_pkg::CAL_BIAS_WAIT; // see R12
               good_d  = 1'b0;
            end else if (pll_sense_i.cal_done) begin
               state_d = spsc_pkg::CAL_IDLE;
               good_d  = pll_sense_i.cal_ok; // see R3
            end
         end
         default: begin
            state_d = spsc_pkg::CAL_IDLE;
         end
      endcase
      if (!enable_d[spsc_pkg::BIT_ENABLE]) begin
         state_d          = spsc_pkg::CAL_IDLE;
         good_d           = 1'b0;
         ctrl_d.cal_start = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= spsc_pkg::CAL_IDLE;
         good_q  <= 1'b0;
         ctrl_q  <= '0;
      end else begin
         state_q <= state_d;
         good_q  <= good_d;
         ctrl_q  <= ctrl_d;
      end
   end

   // ------------------------------------------------------------
   // Status capture
   // ------------------------------------------------------------
   always_comb begin
      status_d                            = spsc_pkg::RST_ZERO; // see R14
      status_d[spsc_pkg::BIT_PUMP_HIGH]   = pll_sense_i.pump_high; // see R1
      status_d[spsc_pkg::BIT_PUMP_LOW]    = pll_sense_i.pump_low; // see R2
      status_d[spsc_pkg::BIT_CAL_GOOD]    = good_q; // see R3
      status_d[spsc_pkg::BIT_OSC_CAL_RUN] = (state_q == spsc_pkg::CAL_RUN); // see R4
      status_d[spsc_pkg::BIT_BIAS_OK]     = pll_sense_i.bias_ok; // see R5
      status_d[spsc_pkg::BIT_LOCKED]      = pll_sense_i.locked; // see R6
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         status_q <= spsc_pkg::RST_ZERO;
      end else begin
         status_q <= status_d;
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_comb begin
      rvalid_d = cfg_rd_i;
      rdata_d  = spsc_pkg::RST_ZERO;
      if (cfg_rd_i) begin
         case (cfg_addr_i)
            spsc_pkg::ADDR_PLL_ENABLE: rdata_d = enable_q;
            spsc_pkg::ADDR_PLL_STATUS: rdata_d = status_q;
            spsc_pkg::ADDR_REF_DIV:    rdata_d = ref_div_q;
            spsc_pkg::ADDR_TERM_CAL:   rdata_d = term_q;
            spsc_pkg::ADDR_LINK_CTRL0: rdata_d = link0_q;
            default:                   rdata_d = spsc_pkg::RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q  <= spsc_pkg::RST_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // ------------------------------------------------------------
   // Reference divider
   // ------------------------------------------------------------
   spsc_ref_divider u_ref_div (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .ref_tick_i (ref_tick_i),
      .div_sel_i  (ctrl_q.div_sel),
      .pfd_tick_o (pfd_tick_o)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign cfg_rdata_o      = rdata_q;
   assign cfg_rvalid_o     = rvalid_q;
   assign pll_ctrl_o       = ctrl_q;
   assign term_cal_start_o = term_start_q;
   assign link_en_o        = link0_q[spsc_pkg::BIT_LINK_EN];
   assign checksum_mode_o  = link0_q[spsc_pkg::BIT_CHECKSUM];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence seq_term_rise;
      wr_term && !term_q[spsc_pkg::BIT_TERM_TRIG] && cfg_wdata_i[spsc_pkg::BIT_TERM_TRIG];
   endsequence

   sequence seq_recal_rise;
      wr_enable && enable_q[spsc_pkg::BIT_ENABLE] && cfg_wdata_i[spsc_pkg::BIT_ENABLE]
      && !enable_q[spsc_pkg::BIT_RECAL] && cfg_wdata_i[spsc_pkg::BIT_RECAL];
   endsequence

   AST_PUMP_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R1
      pll_sense_i.pump_high |=> status_q[spsc_pkg::BIT_PUMP_HIGH])
      else $error("pump high flag missing");

   AST_PUMP_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R2
      pll_sense_i.pump_low |=> status_q[spsc_pkg::BIT_PUMP_LOW])
      else $error("pump low flag missing");

   AST_CAL_GOOD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R3
      (state_q == spsc_pkg::CAL_RUN && pll_sense_i.cal_done && pll_sense_i.cal_ok
       && !cal_trigger && enable_d[spsc_pkg::BIT_ENABLE])
      |=> ##1 status_q[spsc_pkg::BIT_CAL_GOOD])
      else $error("calibration good flag not set");

   AST_CAL_RUNNING: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R4
      (state_q == spsc_pkg::CAL_RUN) |=> status_q[spsc_pkg::BIT_OSC_CAL_RUN])
      else $error("running flag missing");

   AST_BIAS: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R5
      !pll_sense_i.bias_ok |=> !status_q[spsc_pkg::BIT_BIAS_OK])
      else $error("bias flag set while not ready");

   AST_LOCK: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R6
      pll_sense_i.locked |=> status_q[spsc_pkg::BIT_LOCKED])
      else $error("lock flag missing");

   AST_TERM_START: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R11
      seq_term_rise |=> term_cal_start_o ##1 !term_cal_start_o)
      else $error("termination calibration not started");

   AST_RECAL: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R12
      seq_recal_rise
      |=> (state_q == spsc_pkg::CAL_BIAS_WAIT) && !status_d[spsc_pkg::BIT_CAL_GOOD])
      else $error("recalibration not restarted");

   AST_ENABLE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R13
      (wr_enable && !enable_q[spsc_pkg::BIT_ENABLE] && cfg_wdata_i[spsc_pkg::BIT_ENABLE])
      |=> pll_ctrl_o.enable && state_q == spsc_pkg::CAL_BIAS_WAIT)
      else $error("enable did not start calibration");

   AST_STATUS_RO: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see R14
      (cfg_wr_i && hit(cfg_addr_i, spsc_pkg::ADDR_PLL_STATUS))
      |=> status_q[7:6] == 2'h0 && $stable(enable_q) && $stable(ref_div_q)
          && $stable(term_q) && $stable(link0_q))
      else $error("status register changed by write");

endmodule : spsc_pll_regs

// File: testbench/rx_pll_status_config_bench.sv
`timescale 1ns/10ps
module rx_pll_status_config_bench;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                      sys_clk;
   logic                      rst;
   logic [11:0]               cfg_addr;
   logic                      cfg_wr;
   logic                      cfg_rd;
   logic [7:0]                cfg_wdata;
   logic [7:0]                cfg_rdata;
   logic                      cfg_rvalid;
   spsc_pkg::spsc_pll_sense_t sense;
   spsc_pkg::spsc_pll_ctrl_t  ctrl;
   logic                      ref_tick;
   logic                      pfd_tick;
   logic                      term_start;
   logic                      link_en;
   logic                      checksum_mode;
   int                        fails;
   int                        cmp_count;
   int                        cycles;
   logic [31:0]               lfsr_q;
   logic [7:0]                rd_val;

   spsc_pll_regs spsc_pll_regs_i (
      .sys_clk_i        (sys_clk),
      .rst_i            (rst),
      .cfg_addr_i       (cfg_addr),
      .cfg_wr_i         (cfg_wr),
      .cfg_rd_i         (cfg_rd),
      .cfg_wdata_i      (cfg_wdata),
      .cfg_rdata_o      (cfg_rdata),
      .cfg_rvalid_o     (cfg_rvalid),
      .pll_sense_i      (sense),
      .pll_ctrl_o       (ctrl),
      .ref_tick_i       (ref_tick),
      .pfd_tick_o       (pfd_tick),
      .term_cal_start_o (term_start),
      .link_en_o        (link_en),
      .checksum_mode_o  (checksum_mode)
   );

   // ------------------------------------------------------------
   // Clock and timeout
   // ------------------------------------------------------------
   always #2 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         finish_test();
      end
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next

   function automatic int div_of(input logic [1:0] code);
      return (code == 2'h0) ? 4 : (code == 2'h1) ? 2 : 1;
   endfunction : div_of

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [11:0] addr, input logic [7:0] data);
      @(negedge sys_clk);
      cfg_addr  = addr;
      cfg_wdata = data;
      cfg_wr    = 1'b1;
      @(negedge sys_clk);
      cfg_wr    = 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] addr, output logic [7:0] data);
      @(negedge sys_clk);
      cfg_addr = addr;
      cfg_rd   = 1'b1;
      @(negedge sys_clk);
      check("rvalid", {7'h00, cfg_rvalid}, 8'h01);
      data     = cfg_rdata;
      cfg_rd   = 1'b0;
      @(negedge sys_clk);
      check("rvalid end", {7'h00, cfg_rvalid}, 8'h00);
   endtask : rd

   task automatic wait_cal_start();
      int n;
      n = 0;
      while (ctrl.cal_start !== 1'b1 && n < 10) begin
         @(negedge sys_clk);
         n++;
      end
      check("cal_start", {7'h00, ctrl.cal_start}, 8'h01);
   endtask : wait_cal_start

   task automatic finish_test();
      if (fails == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int          n;
      logic [1:0]  code;
      logic [7:0]  exp;
      sys_clk   = 1'b0;
      rst       = 1'b1;
      cfg_addr  = 12'h000;
      cfg_wr    = 1'b0;
      cfg_rd    = 1'b0;
      cfg_wdata = 8'h00;
      sense     = '0;
      ref_tick  = 1'b0;
      fails     = 0;
      cmp_count = 0;
      cycles    = 0;
      lfsr_q    = 32'h00017925;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;

      // Reset values and unmapped address
      rd(spsc_pkg::ADDR_PLL_STATUS, rd_val); check("status rst", rd_val, 8'h00);
      rd(spsc_pkg::ADDR_REF_DIV, rd_val);    check("refdiv rst", rd_val, 8'h04);
      rd(spsc_pkg::ADDR_TERM_CAL, rd_val);   check("term rst", rd_val, 8'h00);
      rd(spsc_pkg::ADDR_LINK_CTRL0, rd_val); check("link rst", rd_val, 8'h00);
      rd(12'h123, rd_val);                   check("unmapped", rd_val, 8'h00);

      // Live status flags with random sense and ignored writes
      for (int i = 0; i < 8; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         sense  = '0;
         sense.pump_high = lfsr_q[0];
         sense.pump_low  = lfsr_q[1];
         sense.bias_ok   = lfsr_q[2];
         sense.locked    = lfsr_q[3];
         wr(spsc_pkg::ADDR_PLL_STATUS, lfsr_q[15:8]);
         exp = {2'h0, lfsr_q[0], lfsr_q[1], 2'h0, lfsr_q[2], lfsr_q[3]};
         rd(spsc_pkg::ADDR_PLL_STATUS, rd_val);
         check("status live", rd_val, exp);
      end
      sense = '0;

      // Divider codes
      for (int c = 0; c < 4; c++) begin
         code = c[1:0];
         wr(spsc_pkg::ADDR_REF_DIV, {6'h3f, code});
         check("div_sel", {6'h00, ctrl.div_sel}, {6'h00, code});
         rd(spsc_pkg::ADDR_REF_DIV, rd_val);
         check("refdiv rb", rd_val, {6'h3f, code});
         n = 0;
         for (int k = 0; k < 16; k++) begin
            @(negedge sys_clk);
            if (pfd_tick === 1'b1) n++;
            ref_tick = (k < 12);
         end
         check("pfd count", n[7:0], 8'(12 / div_of(code)));
      end

      // Termination trigger edges
      wr(spsc_pkg::ADDR_TERM_CAL, 8'hff);
      check("term edge", {7'h00, term_start}, 8'h01);
      wr(spsc_pkg::ADDR_TERM_CAL, 8'h01);
      check("term hold", {7'h00, term_start}, 8'h00);
      rd(spsc_pkg::ADDR_TERM_CAL, rd_val);  check("term rb", rd_val, 8'h01);
      wr(spsc_pkg::ADDR_TERM_CAL, 8'h00);
      wr(spsc_pkg::ADDR_TERM_CAL, 8'h01);
      check("term again", {7'h00, term_start}, 8'h01);

      // Calibration after enable
      wr(spsc_pkg::ADDR_PLL_ENABLE, 8'h01);
      check("enable", {7'h00, ctrl.enable}, 8'h01);
      rd(spsc_pkg::ADDR_PLL_STATUS, rd_val);
      check("no run yet", rd_val & 8'h0c, 8'h00);
      @(negedge sys_clk);
      sense.bias_ok = 1'b1;
      wait_cal_start();
      repeat (3) @(negedge sys_clk);
      rd(spsc_pkg::ADDR_PLL_STATUS, rd_val);
      check("running", rd_val, 8'h06);
      sense.cal_ok   = 1'b1;
      sense.cal_done = 1'b1;
      @(negedge sys_clk);
      sense.cal_done = 1'b0;
      repeat (2) @(negedge sys_clk);
      rd(spsc_pkg::ADDR_PLL_STATUS, rd_val);
      check("cal good", rd_val, 8'h0a);

      // Recalibrate edge, failed outcome
      wr(spsc_pkg::ADDR_PLL_ENABLE, 8'h05);
      wait_cal_start();
      repeat (2) @(negedge sys_clk);
      rd(spsc_pkg::ADDR_PLL_STATUS, rd_val);
      check("recal run", rd_val, 8'h06);
      sense.cal_ok   = 1'b0;
      sense.cal_done = 1'b1;
      @(negedge sys_clk);
      sense.cal_done = 1'b0;
      repeat (2) @(negedge sys_clk);
      rd(spsc_pkg::ADDR_PLL_STATUS, rd_val);
      check("cal bad", rd_val, 8'h02);
      rd(spsc_pkg::ADDR_PLL_ENABLE, rd_val); check("enable rb", rd_val, 8'h05);
      wr(spsc_pkg::ADDR_PLL_ENABLE, 8'h00);
      check("disable", {7'h00, ctrl.enable}, 8'h00);

      // Link control with random data
      for (int i = 0; i < 4; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         wr(spsc_pkg::ADDR_LINK_CTRL0, lfsr_q[7:0]);
         check("link_en", {7'h00, link_en}, {7'h00, lfsr_q[0]});
         check("checksum", {7'h00, checksum_mode}, {7'h00, lfsr_q[6]});
         rd(spsc_pkg::ADDR_LINK_CTRL0, rd_val);
         check("link rb", rd_val, lfsr_q[7:0] & 8'h41);
      end

      // Reset in mid-run
      sense = '0;
      @(negedge sys_clk);
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      rd(spsc_pkg::ADDR_REF_DIV, rd_val);    check("refdiv rst2", rd_val, 8'h04);
      rd(spsc_pkg::ADDR_LINK_CTRL0, rd_val); check("link rst2", rd_val, 8'h00);
      rd(spsc_pkg::ADDR_PLL_STATUS, rd_val); check("status rst2", rd_val, 8'h00);
      check("ctrl rst2", {4'h0, ctrl}, 8'h00);
      finish_test();
   end

endmodule : rx_pll_status_config_bench
